/* rtl/mvr_pkg.sv */
package mvr_pkg;

  // ----------------------------------------
  // holding-register map, offsets from 0
  // ----------------------------------------
  localparam logic [15:0] TAG_LO    = 16'h0000;  // offset 0
  localparam logic [15:0] TAG_HI    = 16'h03E8;  // offset 1000
  localparam logic [15:0] RES_LO    = 16'h03E9;  // offset 1001
  localparam logic [15:0] RES_HI    = 16'h2327;  // offset 8999
  localparam logic [15:0] DIAG_LO   = 16'h2328;  // offset 9000
  localparam logic [15:0] DIAG_HI   = 16'h2347;  // offset 9031
  localparam logic [10:0] TAG_WORDS = 11'h3E9;   // 1001 words in the tag area
  localparam int          TAG_NUM   = 1001;
  localparam logic [8:0]  NUM_TAGS  = 9'h1F4;    // 500 tags
  localparam int          DIAG_BITS = 512;       // 32 registers of 16 bits

  // ----------------------------------------
  // function and exception codes
  // ----------------------------------------
  localparam logic [7:0] FC_READ   = 8'h03;
  localparam logic [7:0] FC_WRITE  = 8'h06;
  localparam logic [7:0] EXC_NONE  = 8'h00;
  localparam logic [7:0] EXC_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ADDR  = 8'h02;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [10:0] NEXT_FREE_RST = 11'h000;

  typedef enum logic [3:0] {
    SRC_S8, SRC_S16, SRC_S32, SRC_S48, SRC_S64, SRC_F32, SRC_DATE,
    SRC_BCD4, SRC_BCD8, SRC_BCD12
  } mvr_src_t;

  typedef enum logic [2:0] {
    TGT_I16, TGT_U16, TGT_I32, TGT_U32, TGT_U64, TGT_R32M, TGT_R32L, TGT_DT32
  } mvr_tgt_t;

endpackage

/* rtl/mvr_map.sv */
`timescale 1ns/100ps
module mvr_map
  import mvr_pkg::*;
(
  input  wire logic        core_clk_i,        // 20 MHz clock
  input  wire logic        rst_n_i,           // synchronous reset, active low
  input  wire logic        mv_valid_i,        // meter value strobe
  input  wire logic [8:0]  mv_tag_i,          // tag index, 0 is tag 1
  input  wire mvr_src_t    mv_src_i,          // source data type
  input  wire logic [63:0] mv_data_i,         // raw meter data, right aligned
  input  wire logic        mv_fail_i,         // meter read timed out
  input  wire logic        cfg_valid_i,       // tag configuration strobe
  input  wire logic [8:0]  cfg_tag_i,         // tag index to configure
  input  wire mvr_src_t    cfg_src_i,         // source type of the tag
  input  wire logic        cfg_auto_start_i,  // pick start register automatically
  input  wire logic [9:0]  cfg_start_i,       // manual start offset
  input  wire logic        cfg_auto_type_i,   // pick target type automatically
  input  wire mvr_tgt_t    cfg_type_i,        // manual target type
  input  wire logic        req_valid_i,       // master request strobe
  input  wire logic [7:0]  req_func_i,        // function code
  input  wire logic [15:0] req_addr_i,        // register offset
  input  wire logic [15:0] req_wdata_i,       // write data for function 6
  output logic             resp_valid_o,      // answer strobe
  output logic [15:0]      resp_data_o,       // read data or write echo
  output logic [7:0]       resp_exc_o,        // exception code, 0 when none
  output logic             cfg_done_o,        // configuration accepted
  output logic             cfg_err_o,         // configuration refused
  output logic [10:0]      next_free_o        // offset just past the highest allocated tag word
);

  // ----------------------------------------
  // conversion helpers
  // ----------------------------------------
  function automatic logic [63:0] bcd_bin(input logic [47:0] d, input int nd);
    logic [63:0] acc;
    acc = 64'h0;
    for (int i = 11; i >= 0; i--) begin
      if (i < nd) begin
        acc = acc * 64'hA + {60'h0, d[i*4 +: 4]};
      end
    end
    return acc;
  endfunction

  // truncating conversion: low mantissa bits are dropped
  function automatic logic [31:0] int_to_f32(input logic [63:0] v);
    logic        sgn;
    logic [63:0] mag;
    logic [5:0]  p;
    logic [63:0] sh;
    logic [31:0] r;
    sgn = v[63];
    mag = sgn ? (~v + 64'h1) : v;
    p   = 6'h0;
    for (int i = 0; i < 64; i++) begin
      if (mag[i]) begin
        p = 6'(i);
      end
    end
    sh = mag << (6'h3F - p);
    r  = {sgn, 8'h7F + {2'h0, p}, sh[62:40]};
    if (mag == 64'h0) begin
      r = 32'h0;
    end
    return r;
  endfunction

  function automatic logic [63:0] src_to_int(input mvr_src_t s, input logic [63:0] d);
    logic [63:0] r;
    case (s)
      SRC_S8:    r = {{56{d[7]}}, d[7:0]};
      SRC_S16:   r = {{48{d[15]}}, d[15:0]};
      SRC_S32:   r = {{32{d[31]}}, d[31:0]};
      SRC_S48:   r = {{16{d[47]}}, d[47:0]};
      SRC_S64:   r = d;
      SRC_BCD4:  r = bcd_bin(d[47:0], 4);
      SRC_BCD8:  r = bcd_bin(d[47:0], 8);
      SRC_BCD12: r = bcd_bin(d[47:0], 12);
      default:   r = {32'h0, d[31:0]};
    endcase
    return r;
  endfunction

  function automatic mvr_tgt_t auto_tgt(input mvr_src_t s);
    mvr_tgt_t t;
    case (s)
      SRC_S8, SRC_S16:           t = TGT_I16;
      SRC_S32:                   t = TGT_I32;
      SRC_S48, SRC_S64, SRC_F32: t = TGT_R32M;
      SRC_DATE:                  t = TGT_DT32;
      SRC_BCD4:                  t = TGT_U16;
      SRC_BCD8:                  t = TGT_U32;
      SRC_BCD12:                 t = TGT_U64;
      default:                   t = TGT_U16;
    endcase
    return t;
  endfunction

  function automatic logic [2:0] tgt_words(input mvr_tgt_t t);
    logic [2:0] n;
    case (t)
      TGT_I16, TGT_U16: n = 3'h1;
      TGT_U64:          n = 3'h4;
      default:          n = 3'h2;
    endcase
    return n;
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0]        tag_mem_m  [0:TAG_NUM-1];
  logic [9:0]         tag_start_m[0:511];
  mvr_tgt_t           tag_type_m [0:511];
  logic [511:0]       tag_cfg_r;
  logic [TAG_NUM-1:0] alloc_r;
  logic [DIAG_BITS-1:0] diag_r;
  logic [10:0]        next_free_r;

  // ----------------------------------------
  // configuration path
  // ----------------------------------------
  mvr_tgt_t    cfg_type_w;
  logic [2:0]  cfg_n_w;
  logic [9:0]  cfg_start_w;
  logic [10:0] cfg_end_w;
  logic        cfg_ok_w;

  assign cfg_type_w  = cfg_auto_type_i ? auto_tgt(cfg_src_i) : cfg_type_i;
  assign cfg_start_w = cfg_auto_start_i ? next_free_r[9:0] : cfg_start_i;
  assign cfg_n_w     = tgt_words(cfg_type_w);
  assign cfg_end_w   = {1'b0, cfg_start_w} + {8'h0, cfg_n_w};
  assign cfg_ok_w    = (cfg_tag_i < NUM_TAGS) && (cfg_end_w <= TAG_WORDS);

  // ----------------------------------------
  // meter update path
  // ----------------------------------------
  logic        upd_ok_w;
  logic        upd_wr_w;
  mvr_tgt_t    upd_type_w;
  logic [9:0]  upd_start_w;
  logic [2:0]  upd_n_w;
  logic [63:0] upd_int_w;
  logic [31:0] upd_flt_w;
  logic [63:0] upd_val_w;
  logic [15:0] upd_word_w [0:3];

  assign upd_ok_w    = mv_valid_i && (mv_tag_i < NUM_TAGS) && tag_cfg_r[mv_tag_i];
  assign upd_wr_w    = upd_ok_w && !mv_fail_i;
  assign upd_type_w  = tag_type_m[mv_tag_i];
  assign upd_start_w = tag_start_m[mv_tag_i];
  assign upd_n_w     = tgt_words(upd_type_w);
  assign upd_int_w   = src_to_int(mv_src_i, mv_data_i);
  assign upd_flt_w   = (mv_src_i == SRC_F32) ? mv_data_i[31:0] : int_to_f32(upd_int_w);

  // value sits in the low 16*n bits; narrowing targets simply truncate
  assign upd_val_w =
    (upd_type_w == TGT_I16 || upd_type_w == TGT_U16) ? {48'h0, upd_int_w[15:0]} :
    (upd_type_w == TGT_I32 || upd_type_w == TGT_U32) ? {32'h0, upd_int_w[31:0]} :
    (upd_type_w == TGT_U64)  ? upd_int_w :
    (upd_type_w == TGT_R32M) ? {32'h0, upd_flt_w} :
    (upd_type_w == TGT_R32L) ? {32'h0, upd_flt_w[15:0], upd_flt_w[31:16]} :
    {32'h0, mv_data_i[31:0]};

  // word k lands at register start+k, most significant word first
  genvar gk;
  generate
    for (gk = 0; gk < 4; gk++) begin : g_lane
      logic [2:0] sel_w;
      assign sel_w = upd_n_w - 3'(gk) - 3'h1;
      assign upd_word_w[gk] = upd_val_w[{sel_w[1:0], 4'h0} +: 16];
    end
  endgenerate

  // ----------------------------------------
  // master request decode
  // ----------------------------------------
  logic        is_tag_w;
  logic        is_res_w;
  logic        is_diag_w;
  logic        fc_ok_w;
  logic [9:0]  tag_a_w;
  logic [4:0]  diag_idx_w;
  logic [15:0] diag_off_w;
  logic [15:0] rd_word_w;
  logic        wr_ok_w;
  logic [7:0]  exc_w;

  assign is_tag_w   = req_addr_i <= TAG_HI;
  assign is_res_w   = (req_addr_i >= RES_LO) && (req_addr_i <= RES_HI);
  assign is_diag_w  = (req_addr_i >= DIAG_LO) && (req_addr_i <= DIAG_HI);
  assign fc_ok_w    = (req_func_i == FC_READ) || (req_func_i == FC_WRITE);
  assign tag_a_w    = req_addr_i[9:0];
  assign diag_off_w = req_addr_i - DIAG_LO;
  assign diag_idx_w = diag_off_w[4:0];

  // reserved and unallocated words read as zero
  assign rd_word_w =
    (is_tag_w && alloc_r[tag_a_w]) ? tag_mem_m[tag_a_w] :
    is_diag_w ? diag_r[{diag_idx_w, 4'h0} +: 16] :
    16'h0000;

  // the diagnostic area is read-only; writes only reach allocated tag words
  assign wr_ok_w = is_tag_w && alloc_r[tag_a_w];
  assign exc_w =
    !fc_ok_w ? EXC_FUNC :
    !(is_tag_w || is_res_w || is_diag_w) ? EXC_ADDR :
    ((req_func_i == FC_WRITE) && !wr_ok_w) ? EXC_ADDR :
    EXC_NONE;

  // ----------------------------------------
  // tag table, allocation and diagnostics
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tag_cfg_r   <= '0;
      alloc_r     <= '0;
      next_free_r <= NEXT_FREE_RST;
      cfg_done_o  <= 1'b0;
      cfg_err_o   <= 1'b0;
    end else begin
      cfg_done_o <= cfg_valid_i && cfg_ok_w;
      cfg_err_o  <= cfg_valid_i && !cfg_ok_w;
      if (cfg_valid_i && cfg_ok_w) begin
        tag_cfg_r[cfg_tag_i] <= 1'b1;
        for (int k = 0; k < 4; k++) begin
          if (3'(k) < cfg_n_w) begin
            alloc_r[cfg_start_w + 10'(k)] <= 1'b1;
          end
        end
        if (cfg_end_w > next_free_r) begin
          next_free_r <= cfg_end_w;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (cfg_valid_i && cfg_ok_w) begin
      tag_start_m[cfg_tag_i] <= cfg_start_w;
      tag_type_m[cfg_tag_i]  <= cfg_type_w;
    end
  end

  // a timed-out read keeps the last good value and only flags the tag
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      diag_r <= '0;
    end else if (upd_ok_w) begin
      diag_r[mv_tag_i] <= mv_fail_i;
    end
  end

  // meter data wins over a master write to the same word in one cycle
  always_ff @(posedge core_clk_i) begin
    if (req_valid_i && req_func_i == FC_WRITE && wr_ok_w) begin
      tag_mem_m[tag_a_w] <= req_wdata_i;
    end
    if (upd_wr_w) begin
      for (int k = 0; k < 4; k++) begin
        if (3'(k) < upd_n_w) begin
          tag_mem_m[upd_start_w + 10'(k)] <= upd_word_w[k];
        end
      end
    end
  end

  // ----------------------------------------
  // answer to the master
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      resp_valid_o <= 1'b0;
      resp_data_o  <= 16'h0000;
      resp_exc_o   <= EXC_NONE;
    end else begin
      resp_valid_o <= req_valid_i;
      if (req_valid_i) begin
        resp_exc_o  <= exc_w;
        resp_data_o <= (exc_w != EXC_NONE) ? 16'h0000 :
                       (req_func_i == FC_WRITE) ? req_wdata_i : rd_word_w;
      end
    end
  end

  assign next_free_o = next_free_r;

endmodule

/* testbench/mvr_map_chk.sv */
`timescale 1ns/100ps
module mvr_map_chk
  import mvr_pkg::*;
(
  input wire logic        core_clk_i,        // clock
  input wire logic        rst_n_i,           // reset, active low
  input wire logic        req_valid_i,       // request strobe
  input wire logic [7:0]  req_func_i,        // function code
  input wire logic [15:0] req_addr_i,        // register offset
  input wire logic        cfg_valid_i,       // config strobe
  input wire logic [8:0]  cfg_tag_i,         // tag to configure
  input wire mvr_src_t    cfg_src_i,         // source type
  input wire logic        cfg_auto_start_i,  // automatic start
  input wire logic        cfg_auto_type_i,   // automatic type
  input wire logic        resp_valid_o,      // answer strobe
  input wire logic [15:0] resp_data_o,       // answer data
  input wire logic [7:0]  resp_exc_o,        // exception code
  input wire logic        cfg_done_o,        // config accepted
  input wire logic        cfg_err_o,         // config refused
  input wire logic [10:0] next_free_o        // offset past the highest allocated word
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic fc_ok;
  assign fc_ok = (req_func_i == FC_READ) || (req_func_i == FC_WRITE);
  chk_resp_latency: assert property (req_valid_i |=> resp_valid_o)
    else $error("no answer one cycle after request");
  chk_resp_quiet: assert property (
    !req_valid_i |=> !resp_valid_o && $stable(resp_data_o))
    else $error("answer without request");
  chk_bad_func: assert property (
    req_valid_i && !fc_ok |=> resp_exc_o == EXC_FUNC && resp_data_o == 16'h0000)
    else $error("unsupported function not refused");
  chk_addr_beyond: assert property (
    req_valid_i && fc_ok && req_addr_i > DIAG_HI |=> resp_exc_o == EXC_ADDR)
    else $error("offset past diagnostic area not refused");
  chk_reserved_zero: assert property (
    req_valid_i && req_func_i == FC_READ && req_addr_i inside {[RES_LO:RES_HI]}
    |=> resp_data_o == 16'h0000 && resp_exc_o == EXC_NONE)
    else $error("reserved read not zero");
  chk_write_outside: assert property (
    req_valid_i && req_func_i == FC_WRITE && req_addr_i > TAG_HI |=> resp_exc_o == EXC_ADDR)
    else $error("write outside tag area accepted");
  chk_cfg_answer: assert property (cfg_valid_i |=> cfg_done_o != cfg_err_o)
    else $error("config not answered once");
  chk_cfg_quiet: assert property (
    !cfg_valid_i |=> !cfg_done_o && !cfg_err_o && $stable(next_free_o))
    else $error("config answer or allocation without request");
  chk_cfg_bad_tag: assert property (
    cfg_valid_i && cfg_tag_i >= NUM_TAGS |=> cfg_err_o)
    else $error("config of bad tag accepted");
  chk_auto_grow: assert property (
    cfg_valid_i && cfg_auto_start_i && cfg_auto_type_i && cfg_src_i == SRC_S32
    && cfg_tag_i < NUM_TAGS && next_free_o < 11'h3E8
    |=> cfg_done_o && next_free_o == $past(next_free_o) + 11'h002)
    else $error("two-word tag not allocated at next free offset");
endmodule

/* testbench/mvr_master.sv */
`timescale 1ns/100ps
module mvr_master
  import mvr_pkg::*;
(
  input  wire logic        clk_i,         // bus clock
  input  wire logic        resp_valid_i,  // answer strobe
  input  wire logic [15:0] resp_data_i,   // answer data
  input  wire logic [7:0]  resp_exc_i,    // answer exception
  output logic             req_valid_o,   // request strobe
  output logic [7:0]       req_func_o,    // function code
  output logic [15:0]      req_addr_o,    // register offset
  output logic [15:0]      req_wdata_o    // write data
);
  initial begin
    {req_valid_o, req_func_o, req_addr_o, req_wdata_o} = '0;
  end
  // one request at a time; the answer is collected once the taking edge has landed
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, d,
                      output logic v, output logic [15:0] q, output logic [7:0] e);
    @(posedge clk_i);
    #1;
    {req_valid_o, req_func_o, req_addr_o, req_wdata_o} = {1'b1, f, a, d};
    @(posedge clk_i);
    #1;
    // released lines show a fresh pattern so a stale request is never mistaken for live
    {req_valid_o, req_func_o, req_addr_o, req_wdata_o} = {1'b0, ~f, ~a, ~d};
    {v, q, e} = {resp_valid_i, resp_data_i, resp_exc_i};
  endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import mvr_pkg::*;
  typedef struct {mvr_src_t src; logic [63:0] data; int n; logic [63:0] exp;} mvr_row_t;
  logic        clk, rst_n, mv_valid, mv_fail, cfg_valid, cfg_as, cfg_at, cfg_done, cfg_err;
  logic        req_valid, resp_valid;
  logic [8:0]  mv_tag, cfg_tag;
  logic [9:0]  cfg_start;
  logic [7:0]  req_func, resp_exc;
  logic [15:0] req_addr, req_wdata, resp_data;
  logic [10:0] next_free;
  logic [63:0] mv_data;
  mvr_src_t    mv_src, cfg_src;
  mvr_tgt_t    cfg_type;
  int          miscompares, cmp_count;
  mvr_row_t rows[10] = '{
    '{SRC_S8, 64'h80, 1, 64'hFF80}, '{SRC_S16, 64'h8001, 1, 64'h8001},
    '{SRC_S32, 64'h12345678, 2, 64'h12345678}, '{SRC_S48, 64'h2, 2, 64'h40000000},
    '{SRC_S64, 64'h3, 2, 64'h40400000}, '{SRC_F32, 64'h3F800000, 2, 64'h3F800000},
    '{SRC_DATE, 64'hABCD1234, 2, 64'hABCD1234}, '{SRC_BCD4, 64'h9876, 1, 64'h2694},
    '{SRC_BCD8, 64'h12345678, 2, 64'hBC614E}, '{SRC_BCD12, 64'h123456789012, 4, 64'h1CBE991A14}};
  mvr_map dut (.core_clk_i(clk), .rst_n_i(rst_n), .mv_valid_i(mv_valid), .mv_tag_i(mv_tag),
    .mv_src_i(mv_src), .mv_data_i(mv_data), .mv_fail_i(mv_fail), .cfg_valid_i(cfg_valid),
    .cfg_tag_i(cfg_tag), .cfg_src_i(cfg_src), .cfg_auto_start_i(cfg_as), .cfg_start_i(cfg_start),
    .cfg_auto_type_i(cfg_at), .cfg_type_i(cfg_type), .req_valid_i(req_valid),
    .req_func_i(req_func), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
    .resp_valid_o(resp_valid), .resp_data_o(resp_data), .resp_exc_o(resp_exc),
    .cfg_done_o(cfg_done), .cfg_err_o(cfg_err), .next_free_o(next_free));
  mvr_master partner (.clk_i(clk), .resp_valid_i(resp_valid), .resp_data_i(resp_data),
    .resp_exc_i(resp_exc), .req_valid_o(req_valid), .req_func_o(req_func),
    .req_addr_o(req_addr), .req_wdata_o(req_wdata));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] time %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic [7:0] f, input logic [15:0] a, d, q_exp, input logic [7:0] e_exp);
    logic v;
    logic [15:0] q;
    logic [7:0] e;
    partner.xfer(f, a, d, v, q, e);
    check({v, e, q}, {1'b1, e_exp, q_exp});
  endtask
  task automatic cfg(input int t, input mvr_src_t s, input logic as, at, input int st,
                     input mvr_tgt_t ty, input logic ok, input int nf);
    @(posedge clk);
    #1;
    {cfg_valid, cfg_tag, cfg_as, cfg_at, cfg_start} = {1'b1, 9'(t), as, at, 10'(st)};
    cfg_src  = s;
    cfg_type = ty;
    @(posedge clk);
    #1;
    cfg_valid = 1'b0;
    check({cfg_done, cfg_err, next_free}, {ok, !ok, 11'(nf)});
  endtask
  task automatic mv(input int t, input mvr_src_t s, input logic [63:0] d, input logic f);
    @(posedge clk);
    #1;
    {mv_valid, mv_tag, mv_data, mv_fail} = {1'b1, 9'(t), d, f};
    mv_src = s;
    @(posedge clk);
    #1;
    {mv_valid, mv_data} = {1'b0, ~d};
  endtask
  task automatic test_done;
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(20000 * 50);
    miscompares++;
    test_done();
  end
  initial begin
    int nf;
    logic [15:0] rd_a, rd_q;
    {rst_n, mv_valid, mv_tag, mv_data, mv_fail, cfg_valid, cfg_tag, cfg_as, cfg_at, cfg_start} = '0;
    mv_src   = SRC_S8;
    cfg_src  = SRC_S8;
    cfg_type = TGT_I16;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check({resp_valid, resp_data, resp_exc, cfg_done, cfg_err, next_free}, 0);
    nf = 0;
    foreach (rows[i]) begin
      nf += rows[i].n;
      cfg(i, rows[i].src, 1'b1, 1'b1, 0, TGT_I16, 1'b1, nf);
      mv(i, rows[i].src, rows[i].data, 1'b0);
      for (int k = 0; k < rows[i].n; k++) begin
        rd_a = 16'(nf - rows[i].n + k);
        rd_q = 16'(rows[i].exp >> (16 * (rows[i].n - 1 - k)));
        acc(FC_READ, rd_a, 0, rd_q, 8'h00);
      end
    end
    acc(FC_READ, 16'd19, 0, 0, EXC_NONE);
    acc(FC_READ, TAG_HI, 0, 0, EXC_NONE);
    acc(FC_READ, RES_LO, 0, 0, EXC_NONE);
    acc(FC_READ, RES_HI, 0, 0, EXC_NONE);
    acc(FC_READ, DIAG_HI, 0, 0, EXC_NONE);
    acc(FC_READ, DIAG_HI + 16'h0001, 0, 0, EXC_ADDR);
    acc(8'h04, 16'd0, 0, 0, EXC_FUNC);
    acc(FC_WRITE, RES_LO, 16'h5A5A, 0, EXC_ADDR);
    acc(FC_WRITE, DIAG_LO, 16'h5A5A, 0, EXC_ADDR);
    acc(FC_WRITE, 16'd0, 16'hA55A, 16'hA55A, EXC_NONE);
    acc(FC_READ, 16'd0, 0, 16'hA55A, EXC_NONE);
    mv(2, SRC_S32, 64'h1, 1'b1);
    acc(FC_READ, DIAG_LO, 0, 16'h0004, EXC_NONE);
    acc(FC_READ, 16'd2, 0, 16'h1234, EXC_NONE);
    mv(2, SRC_S32, 64'h1, 1'b0);
    acc(FC_READ, DIAG_LO, 0, 0, EXC_NONE);
    acc(FC_READ, 16'd3, 0, 16'h0001, EXC_NONE);
    cfg(17, SRC_S8, 1'b1, 1'b1, 0, TGT_I16, 1'b1, 20);
    mv(17, SRC_S8, 64'h0, 1'b1);
    acc(FC_READ, DIAG_LO + 16'h0001, 0, 16'h0002, EXC_NONE);
    cfg(20, SRC_S32, 1'b0, 1'b0, 500, TGT_R32L, 1'b1, 502);
    mv(20, SRC_S32, 64'h5, 1'b0);
    acc(FC_READ, 16'd500, 0, 16'h0000, EXC_NONE);
    acc(FC_READ, 16'd501, 0, 16'h40A0, EXC_NONE);
    cfg(21, SRC_S8, 1'b0, 1'b0, 998, TGT_U64, 1'b0, 502);
    cfg(21, SRC_S8, 1'b0, 1'b0, 997, TGT_U64, 1'b1, 1001);
    cfg(22, SRC_S32, 1'b1, 1'b1, 0, TGT_I16, 1'b0, 1001);
    cfg(500, SRC_S8, 1'b1, 1'b1, 0, TGT_I16, 1'b0, 1001);
    // meter update and master write land on word 0 at one edge: meter data must win
    fork
      mv(0, SRC_S8, 64'h11, 1'b0);
      acc(FC_WRITE, 16'd0, 16'hBEEF, 16'hBEEF, EXC_NONE);
    join
    acc(FC_READ, 16'd0, 0, 16'h0011, EXC_NONE);
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    check(next_free, 0);
    acc(FC_READ, 16'd0, 0, 0, EXC_NONE);
    acc(FC_READ, DIAG_LO + 16'h0001, 0, 0, EXC_NONE);
    // tag 0 is unconfigured after reset, so this update must be ignored
    mv(0, SRC_S8, 64'h7, 1'b1);
    acc(FC_READ, DIAG_LO, 0, 0, EXC_NONE);
    acc(FC_READ, 16'd0, 0, 0, EXC_NONE);
    test_done();
  end
endmodule
bind mvr_map mvr_map_chk u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .req_valid_i(req_valid_i), .req_func_i(req_func_i), .req_addr_i(req_addr_i),
  .cfg_valid_i(cfg_valid_i), .cfg_tag_i(cfg_tag_i), .cfg_src_i(cfg_src_i),
  .cfg_auto_start_i(cfg_auto_start_i), .cfg_auto_type_i(cfg_auto_type_i),
  .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .resp_exc_o(resp_exc_o),
  .cfg_done_o(cfg_done_o), .cfg_err_o(cfg_err_o), .next_free_o(next_free_o));
